// [hdl/local_bus_config_mailbox.sv]
/*
  Local bus setup register and local-to-host mailbox, reached over APB.
  Assumes a single 10 MHz clock, synchronous inputs and a host side that
  pulses hostIrqClear when its control register clears the mailbox event.
*/
// The APB interface to the registers was decided locally.
// What this block does
// [RQ1] Mailbox bit 24 write raises host interrupt
// [RQ2] Bit 24 is write only, reads zero
// [RQ3] Mailbox holds two bytes for host
// [RQ4] Bit 20 disables cache line wrapping
// [RQ5] Bit 19 selects ready-in sampling edge
// [RQ6] Bit 18 sets chip-choose active level
// [RQ7] Bit 17 selects chip-choose sampling edge
// [RQ8] Bit 16 tri-states ready-out when idle
// [RQ9] Bit 15 extends ready-out; not with mode
// [RQ10] Bit 14 selects linear or interleaved bursts
// [RQ11] Bit 13 sets local interrupt polarity
// [RQ12] Bits 12:10 set burst, latch, ready levels
// [RQ13] Bits 9:8 select local bus width
// [RQ14] Bit 7 sets burst-last interpretation
// [RQ15] Bits 5:4 set read/write pin meaning
// [RQ16] Bit 2 sets address strobe polarity
// [RQ17] Bit 1 delays write data capture
// [RQ18] Bit 0 delays read data output
// [RQ19] Reset loads defaults, clears mailbox; setupOut is zero in reset, defaults from the first clock after
`timescale 1ns/1ps
module local_bus_config_mailbox
  import lbus_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host side of the mailbox
  input wire logic hostIrqClear,
  output lbus_pkg::mailbox_t hostMailbox,
  // Decoded setup toward the local bus engine
  output lbus_pkg::setup_t setupOut,
  // Local interrupt
  output logic irqOut
);
  import lbus_pkg::*;

  // Decoder compares the low address bits only
  if (ADDR_W < `ADDR_DEC_W) begin : g_addr_check
    $error("ADDR_W must cover offset range");
  end

  // ==========================================================
  // Address decode
  // Side effects only at the edge that completes the transfer
  wire logic access = psel && penable && pready;
  wire logic answerNow = psel && penable && !pready;
  wire logic [`ADDR_DEC_W-1:0] addrLow = paddr[`ADDR_DEC_W-1:0];
  wire logic hitSetup = addrLow == `OFF_SETUP;
  wire logic hitMbox = addrLow == `OFF_MAILBOX;
  wire logic hitStat = addrLow == `OFF_IRQ_STAT;
  wire logic hitMask = addrLow == `OFF_IRQ_MASK;
  wire logic hitAny = hitSetup || hitMbox || hitStat || hitMask;
  wire logic wrSetup = access && pwrite && hitSetup;
  wire logic wrMbox = access && pwrite && hitMbox;
  wire logic wrMask = access && pwrite && hitMask;
  wire logic rdStat = access && !pwrite && hitStat;

  // ==========================================================
  // Registers
  logic [31:0] setup_r;
  logic [15:0] mboxData_r;
  logic hostIrq_r;
  logic [`IRQ_EVT_W-1:0] irqStat_r;
  logic [`IRQ_EVT_W-1:0] irqMask_r;

  // Write mask keeps reserved bits at zero; bit 3 is stored but feeds no field
  wire logic [31:0] setupWr = pwdata & `SETUP_WMASK_LOW;
  wire logic [31:0] setup_nxt = wrSetup ? setupWr : setup_r; // RQ4

  // Set wins over host clear so a fresh doorbell is never lost
  wire logic raiseHost = wrMbox && pwdata[`BIT_HOST_IRQ]; // RQ1
  wire logic hostIrq_nxt = raiseHost || (hostIrq_r && !hostIrqClear); // RQ1

  // Events: 0 = doorbell raised, 1 = host took it
  wire logic [`IRQ_EVT_W-1:0] evt = {hostIrq_r && hostIrqClear, raiseHost};
  // Read clears only the bits it returned; a later event stays pending
  wire logic [`IRQ_EVT_W-1:0] readBack = rdStat ? prdata[`IRQ_EVT_W-1:0] : '0;
  wire logic [`IRQ_EVT_W-1:0] irqStat_nxt;
  for (genvar i = 0; i < `IRQ_EVT_W; i++) begin : g_stat
    // Set wins over the read clear
    assign irqStat_nxt[i] = evt[i] || (irqStat_r[i] && !readBack[i]);
  end
  wire logic irqActive = |(irqStat_nxt & irqMask_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_r <= `SETUP_RESET; // RQ19
      mboxData_r <= 16'h0000; // RQ19
      hostIrq_r <= 1'b0; // RQ19
      irqStat_r <= '0;
      irqMask_r <= '0;
    end else begin
      setup_r <= setup_nxt; // RQ5
      if (wrMbox) begin
        mboxData_r <= pwdata[15:0]; // RQ3
      end
      hostIrq_r <= hostIrq_nxt;
      irqStat_r <= irqStat_nxt;
      if (wrMask) begin
        irqMask_r <= pwdata[`IRQ_EVT_W-1:0];
      end
    end
  end

  // ==========================================================
  // Read mux
  wire logic [31:0] mboxRead = {16'h0000, mboxData_r}; // RQ2
  wire logic [31:0] rdData =
    hitSetup ? setup_r :
    hitMbox ? mboxRead :
    hitStat ? {{(32-`IRQ_EVT_W){1'b0}}, irqStat_r} :
    hitMask ? {{(32-`IRQ_EVT_W){1'b0}}, irqMask_r} : 32'h0000_0000;

  // ==========================================================
  // Outputs, all from flip-flops; APB answer with one wait state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      hostMailbox <= '0;
      setupOut <= '0;
      // Inactive level of the default active-low polarity
      irqOut <= 1'b1; // RQ11
    end else begin
      // Ready one cycle into access phase
      pready <= answerNow;
      pslverr <= answerNow && !hitAny;
      prdata <= (answerNow && !pwrite) ? rdData : 32'h0000_0000;
      hostMailbox <= '{data: (wrMbox ? pwdata[15:0] : mboxData_r), hostIrq: hostIrq_nxt};
      setupOut <= '{
        wrapDisable: setup_nxt[`BIT_WRAP_DIS], // RQ4
        readyInFall: setup_nxt[`BIT_RDYIN_FALL], // RQ5
        chipChoosePolarity: setup_nxt[`BIT_CS_POL], // RQ6
        chipChooseFall: setup_nxt[`BIT_CS_FALL], // RQ7
        readyOutTristate: setup_nxt[`BIT_RDYOUT_OE], // RQ8
        // Forbidden combination with whole-burst mode is masked off
        extendedReadyOutput: setup_nxt[`BIT_XTND_RDY] && !setup_nxt[`BIT_BURST_LAST_IN_MODE], // RQ9
        interleavedBurst: setup_nxt[`BIT_BURST_STYLE], // RQ10
        irqPolarity: setup_nxt[`BIT_IRQ_POL], // RQ11
        burstLastPolarity: setup_nxt[`BIT_BURST_LAST_POLARITY], // RQ12
        addrLatchPolarity: setup_nxt[`BIT_ADDR_LATCH_POLARITY], // RQ12
        readyOutputPolarity: setup_nxt[`BIT_READY_OUTPUT_POLARITY], // RQ12
        localBusWidth: setup_nxt[`BIT_BW_HI:`BIT_BW_LO], // RQ13
        burstLastMode: setup_nxt[`BIT_BURST_LAST_IN_MODE], // RQ14
        byteLaneEncoding: setup_nxt[`BIT_BE_ENC],
        rdWrPinMode: setup_nxt[`BIT_RW_HI:`BIT_RW_LO], // RQ15
        addrStrobePolarity: setup_nxt[`BIT_AS_POL], // RQ16
        registeredDataIn: setup_nxt[`BIT_REG_DIN], // RQ17
        registeredDataOut: setup_nxt[`BIT_REG_DOUT] // RQ18
      };
      // Polarity of the local interrupt follows the setup bit
      irqOut <= irqActive ^ !setup_nxt[`BIT_IRQ_POL]; // RQ11
    end
  end
endmodule

// [hdl/lbus_cfg.svh]
/*
  Offsets, field positions and reset values of the local bus setup and
  mailbox block.
  Assumes inclusion by bare name from the package, the checker and the bench.
*/
`ifndef LBUS_CFG_SVH
`define LBUS_CFG_SVH

// ==========================================================
// Register byte addresses
`define OFF_SETUP 12'h4fc
`define OFF_MAILBOX 12'h4f8
`define OFF_IRQ_STAT 12'h4f0
`define OFF_IRQ_MASK 12'h4f4

// ==========================================================
// Field positions
`define BIT_HOST_IRQ 24
`define BIT_WRAP_DIS 20
`define BIT_RDYIN_FALL 19
`define BIT_CS_POL 18
`define BIT_CS_FALL 17
`define BIT_RDYOUT_OE 16
`define BIT_XTND_RDY 15
`define BIT_BURST_STYLE 14
`define BIT_IRQ_POL 13
`define BIT_BURST_LAST_POLARITY 12
`define BIT_ADDR_LATCH_POLARITY 11
`define BIT_READY_OUTPUT_POLARITY 10
`define BIT_BW_HI 9
`define BIT_BW_LO 8
`define BIT_BURST_LAST_IN_MODE 7
`define BIT_BE_ENC 6
`define BIT_RW_HI 5
`define BIT_RW_LO 4
`define BIT_AS_POL 2
`define BIT_REG_DIN 1
`define BIT_REG_DOUT 0

// ==========================================================
// Reset values and masks
`define SETUP_RESET 32'h0001_0b50
`define SETUP_WMASK 32'h001f_fffd
`define SETUP_WMASK_LOW 32'h001f_ffff
`define MBOX_DATA_MASK 32'h0000_ffff
`define IRQ_EVT_W 2
`define ADDR_DEC_W 12

`endif

// [hdl/lbus_pkg.sv]
/*
  Types shared by the local bus setup and mailbox block.
  Assumes lbus_cfg.svh is on the include path.
*/
package lbus_pkg;
  `include "lbus_cfg.svh"

  typedef struct packed {
    logic wrapDisable;
    logic readyInFall;
    logic chipChoosePolarity;
    logic chipChooseFall;
    logic readyOutTristate;
    logic extendedReadyOutput;
    logic interleavedBurst;
    logic irqPolarity;
    logic burstLastPolarity;
    logic addrLatchPolarity;
    logic readyOutputPolarity;
    logic [1:0] localBusWidth;
    logic burstLastMode;
    logic byteLaneEncoding;
    logic [1:0] rdWrPinMode;
    logic addrStrobePolarity;
    logic registeredDataIn;
    logic registeredDataOut;
  } setup_t;

  typedef struct packed {
    logic [15:0] data;
    logic hostIrq;
  } mailbox_t;

  typedef enum logic [1:0] {
    RW_DIR_READ = 2'b00,
    RW_DIR_WRITE = 2'b01,
    RW_STROBE = 2'b10
  } rw_mode_t;
endpackage

// [tb/lbus_props.sv]
/* Checker for the setup and mailbox block ports.
   Assumes lbus_pkg is compiled first; bound at the foot. */
`timescale 1ns/1ps
`include "lbus_cfg.svh"
module lbus_props
  import lbus_pkg::*;
#(parameter int ADDR_W = 12) (
  // Watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hostIrqClear,
  input lbus_pkg::mailbox_t hostMailbox,
  input lbus_pkg::setup_t setupOut,
  input wire logic irqOut
);
  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wrMb = pready && pwrite && paddr[11:0] == `OFF_MAILBOX;
  wire rdMb = pready && !pwrite && paddr[11:0] == `OFF_MAILBOX;
  wire wrSu = pready && pwrite && paddr[11:0] == `OFF_SETUP;
  wire rdSu = pready && !pwrite && paddr[11:0] == `OFF_SETUP;
  a_ready_wait: assert property ($rose(penable) && psel |=> pready) else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_irq_raise: assert property (wrMb && pwdata[`BIT_HOST_IRQ] |=> hostMailbox.hostIrq)
    else $error("doorbell lost");
  a_irq_hold: assert property (hostMailbox.hostIrq && !hostIrqClear |=> hostMailbox.hostIrq)
    else $error("doorbell dropped");
  a_irq_drop: assert property (hostIrqClear && !psel |=> !hostMailbox.hostIrq)
    else $error("doorbell stuck");
  a_mbox_data: assert property (wrMb |=> hostMailbox.data == $past(pwdata[15:0]))
    else $error("mailbox data");
  a_mbox_read: assert property (rdMb |-> prdata == {16'h0, hostMailbox.data})
    else $error("mailbox read");
  a_setup_write: assert property (wrSu && !pwdata[7] |=>
    setupOut == $past({pwdata[20:4], pwdata[2:0]})) else $error("setup write");
  a_xtnd_block: assert property (setupOut.burstLastMode |-> !setupOut.extendedReadyOutput)
    else $error("extension with burst mode");
  a_setup_read: assert property (rdSu |-> prdata[31:21] == 11'h0 && prdata[0] == setupOut.registeredDataOut)
    else $error("setup read");
  cover property (wrMb && pwdata[24]);
  cover property (pslverr);
  cover property (hostIrqClear);
endmodule
bind local_bus_config_mailbox lbus_props #(.ADDR_W(ADDR_W)) chk (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .hostIrqClear(hostIrqClear),
  .hostMailbox(hostMailbox), .setupOut(setupOut), .irqOut(irqOut));

// [tb/host_side.sv]
/* Host software stand-in that clears the mailbox doorbell.
   Acts only while the bench raises ack. */
`timescale 1ns/1ps
module host_side
  import lbus_pkg::*;
(
  // Clock, reset and request
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ack,
  // Mailbox as the host sees it
  input lbus_pkg::mailbox_t mb,
  output logic hostIrqClear
);
  // One-cycle pulse, so a later doorbell is not swallowed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hostIrqClear <= 1'h0;
    end else begin
      hostIrqClear <= ack && mb.hostIrq && !hostIrqClear;
    end
  end
endmodule

// [tb/test_local_bus_config_mailbox.sv]
/* Bench for the setup and mailbox block.
   Assumes lbus_pkg and host_side are compiled first. */
`timescale 1ns/1ps
`include "lbus_cfg.svh"
module test_local_bus_config_mailbox;
  import lbus_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, ack = 1'h0;
  logic [11:0] paddr = 12'h0, a;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, hostIrqClear, irqOut, er;
  mailbox_t mb;
  setup_t su;
  int fails = 0, n_checks = 0, cyc = 0;
  // Address, write data, read-back
  logic [75:0] rows [5] = '{{12'h4fc, 32'h001f7ff7, 32'h001f7ff7},
    {12'h4fc, 32'h00008002, 32'h00008002}, {12'h4fc, 32'h0, 32'h0},
    {12'h4f8, 32'hfefeabcd, 32'h0000abcd}, {12'h4f8, 32'h01001234, 32'h00001234}};
  always #50 clk = ~clk;
  local_bus_config_mailbox dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hostIrqClear(hostIrqClear), .hostMailbox(mb), .setupOut(su),
    .irqOut(irqOut));
  host_side host (.clk(clk), .rst_n(rst_n), .ack(ack), .mb(mb), .hostIrqClear(hostIrqClear));
  function automatic logic [31:0] pk(input logic [31:0] w);
    return {12'h0, w[20:4], w[2:0]};
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rst_chk;
    @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    @(negedge clk);
    chk(32'(su), pk(`SETUP_RESET));
    chk(32'(mb), 32'h0);
    chk(32'(irqOut), 32'h1);
    apb(1'h0, `OFF_SETUP, 32'h0); chk(rd, `SETUP_RESET);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      final_report;
    end
  end
  initial begin
    repeat (19) @(posedge clk);
    rst_chk;
    for (int i = 0; i < 5; i++) begin
      a = rows[i][75:64];
      apb(1'h1, a, rows[i][63:32]);
      @(negedge clk);
      chk(a == `OFF_SETUP ? 32'(su) : 32'(mb.data), a == `OFF_SETUP ? pk(rows[i][31:0]) : rows[i][31:0]);
      apb(1'h0, a, 32'h0); chk(rd, rows[i][31:0]);
    end
    apb(1'h1, `OFF_SETUP, 32'h00008080); @(negedge clk); chk(32'(su.extendedReadyOutput), 32'h0);
    apb(1'h1, `OFF_IRQ_MASK, 32'h1); apb(1'h1, `OFF_MAILBOX, 32'h01000000);
    repeat (2) @(negedge clk);
    chk(32'(mb.hostIrq), 32'h1); chk(32'(irqOut), 32'h0);
    apb(1'h0, `OFF_IRQ_STAT, 32'h0); chk(32'(rd[0]), 32'h1);
    repeat (2) @(negedge clk); chk(32'(irqOut), 32'h1);
    @(posedge clk) ack <= 1'h1;
    repeat (3) @(negedge clk); chk(32'(mb.hostIrq), 32'h0);
    apb(1'h0, `OFF_IRQ_STAT, 32'h0); chk(rd, 32'h2);
    apb(1'h1, `OFF_SETUP, 32'h00002000); repeat (2) @(negedge clk); chk(32'(irqOut), 32'h0);
    apb(1'h0, 12'h100, 32'h0); chk(32'(er), 32'h1); chk(rd, 32'h0);
    // Mid-run reset with data and a doorbell pending
    @(posedge clk) ack <= 1'h0;
    apb(1'h1, `OFF_MAILBOX, 32'h01005a5a);
    @(negedge clk); chk(32'(mb), {15'h0, 16'h5a5a, 1'h1});
    @(posedge clk) rst_n <= 1'h0;
    rst_chk;
    apb(1'h0, `OFF_MAILBOX, 32'h0); chk(rd, 32'h0);
    final_report;
  end
endmodule
